/* ctd_consts.svh */
// Functional notes
// - Touch output follows proximity; baseline frozen meanwhile.
// - Touch entry reloads baseline as frozen minus threshold.
// - In touch, baseline tracks count for drift.
// - Release when count exceeds baseline by release.
// - Qualified high control in charge-halt mode enters standby.
// - Leaving charge-halt standby always reseeds the baseline.
// - Qualified high control in filter-halt freezes filter.
// - Valid pulse reseeds baseline and clears touch output.
// - Out-of-limit count at reseed starts a retune.
// - Retune pulse accepted in any detection state.
// - Polarity bit selects open-drain low or push-pull high.
// - Active-high outputs stay high until first tuning.
// - Proximity needs six consecutive samples over threshold.
// - Proximity code decodes to 4, 2, 8, 16.
// - Touch needs two consecutive samples below threshold.
// - Touch code decodes to eight fractions of baseline.
// - Transfer rate bit selects 512 or 250 kHz.
// - Target bit selects 1200 or 1024 counts.
// - Fast entry skips entry delay, disables AC filters.
// - Fast entry without proximity holds baseline for halt.
// - Filter runs without proximity, and during touch unless held or halted.
// - Halt code 00 is 20 s, 01 is 40 s.
// - Proximity longer than halt time forces a reseed.
`ifndef CTD_CONSTS_SVH
`define CTD_CONSTS_SVH
`define CTD_ADR_CFG0 8'h00
`define CTD_ADR_CFG1 8'h04
`define CTD_ADR_CFG2 8'h08
`define CTD_ADR_CTRL 8'h0c
`define CTD_ADR_STAT 8'h10
`define CTD_ADR_BASE 8'h14
`define CTD_ADR_CNT 8'h18
`define CTD_CFG0_RST 8'h00
`define CTD_CFG1_RST 8'h00
`define CTD_CFG2_RST 8'h00
`define CTD_CTRL_RST 8'h00
`define CTD_CLK_KHZ 50000
`define CTD_XFER_FAST_KHZ 512
`define CTD_XFER_SLOW_KHZ 250
`define CTD_TICK_US 1000
`define CTD_CLK_MHZ 50
`define CTD_PULSE_MIN_MS 25
`define CTD_PULSE_MAX_MS 35
`define CTD_QUAL_MS 40
`define CTD_HALT_20S_MS 20000
`define CTD_HALT_40S_MS 40000
`define CTD_HALT_3S_MS 3000
`define CTD_PROX_RUN 3'd6
`define CTD_TOUCH_RUN 2'd2
`define CTD_TARGET_HI 16'd1200
`define CTD_TARGET_LO 16'd1024
`define CTD_FILT_SHIFT 4
`endif

/* ctd_pkg.sv */
package ctd_pkg;
	typedef enum logic [1:0] {
		CTD_ST_TUNE = 2'b00,
		CTD_ST_NOTOUCH = 2'b01,
		CTD_ST_TOUCH = 2'b10,
		CTD_ST_STANDBY = 2'b11
	} ctd_state_t;
	typedef struct packed {
		logic in_en;
		logic rel_85;
		logic pol_high;
		logic [2:0] tthr_code;
		logic [1:0] pthr_code;
	} ctd_cfg0_t;
	typedef struct packed {
		logic [1:0] halt_code;
		logic [1:0] unused;
		logic fast_touch_entry;
		logic [2:0] base_code;
	} ctd_cfg1_t;
	typedef struct packed {
		logic pulse_retune;
		logic filter_halt_mode;
	} ctd_ctrl_t;
endpackage

/* ctd_detect.sv */
`timescale 1ns/1ps
`include "ctd_consts.svh"
module ctd_detect import ctd_pkg::*; #(
	parameter int TICK_CYCLES = `CTD_TICK_US * `CTD_CLK_MHZ,
	parameter int HALT_20S_TICKS = `CTD_HALT_20S_MS,
	parameter int HALT_40S_TICKS = `CTD_HALT_40S_MS
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic conv_valid,
	input wire logic [15:0] conv_count,
	input wire logic tune_done,
	output logic charge_en,
	output logic tune_start,
	output logic [15:0] tune_target,
	output logic xfer_en,
	output logic ac_filter_en,
	output logic touch_output_pin_o,
	output logic touch_output_pin_oe,
	input wire logic prox_out_cmd_pin_i,
	output logic prox_out_cmd_pin_o,
	output logic prox_out_cmd_pin_oe
);

	////////////////////////////////////////////////////////////////////////////////
	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
	localparam logic [7:0] XFER_FAST = 8'(`CTD_CLK_KHZ / `CTD_XFER_FAST_KHZ - 1);
	localparam logic [7:0] XFER_SLOW = 8'(`CTD_CLK_KHZ / `CTD_XFER_SLOW_KHZ - 1);

	function automatic logic [15:0] pthr_of(input logic [1:0] code);
		case (code)
			2'b00: pthr_of = 16'h0004;
			2'b01: pthr_of = 16'h0002;
			2'b10: pthr_of = 16'h0008;
			default: pthr_of = 16'h0010;
		endcase
	endfunction

	function automatic logic [7:0] tfrac_of(input logic [2:0] code);
		case (code)
			3'b000: tfrac_of = 8'h48;
			3'b001: tfrac_of = 8'h04;
			3'b010: tfrac_of = 8'h08;
			3'b011: tfrac_of = 8'h18;
			3'b100: tfrac_of = 8'h30;
			3'b101: tfrac_of = 8'h60;
			3'b110: tfrac_of = 8'h80;
			default: tfrac_of = 8'ha0;
		endcase
	endfunction

	function automatic logic [15:0] halt_of(input logic [1:0] code);
		case (code)
			2'b00: halt_of = 16'(HALT_20S_TICKS);
			2'b01: halt_of = 16'(HALT_40S_TICKS);
			2'b11: halt_of = 16'(`CTD_HALT_3S_MS);
			default: halt_of = 16'h0000;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	ctd_cfg0_t cfg0_r, cfg0_nxt;
	ctd_cfg1_t cfg1_r, cfg1_nxt;
	logic [7:0] cfg2_r, cfg2_nxt;
	ctd_ctrl_t ctrl_r, ctrl_nxt;
	logic ack_r, ack_nxt;
	logic [31:0] dat_r, dat_nxt;
	ctd_state_t state_r, state_nxt;
	logic [15:0] base_r, base_nxt;
	logic [15:0] count_r, count_nxt;
	logic prox_r, prox_nxt;
	logic [2:0] prun_r, prun_nxt;
	logic [1:0] trun_r, trun_nxt;
	logic seed_r, seed_nxt;
	logic first_r, first_nxt;
	logic hold_r, hold_nxt;
	logic sby_req_r, sby_req_nxt;
	logic [15:0] htmr_r, htmr_nxt;
	logic tstart_r, tstart_nxt;
	logic [15:0] tick_cnt_r, tick_cnt_nxt;
	logic [7:0] xfer_cnt_r, xfer_cnt_nxt;
	logic [15:0] hi_r, hi_nxt;
	logic pin_d_r, pin_d_nxt;
	logic tick;
	logic cmd_reseed, cmd_retune, qual_hi, ext_charge_halt, ext_filter_halt;
	logic [15:0] pthr, tthr, relthr, target, halt_ticks;
	logic [23:0] tprod;
	logic [17:0] rprod;
	logic signed [16:0] dlt;
	logic prox_hit, touch_hit, rel_hit, filt_halt, halt_expired, touch_go;

	////////////////////////////////////////////////////////////////////////////////
	// Writable registers sit in byte lane 0; BASE and CNT also read back in lane 1; other lanes are read-only zero.
	always_comb begin
		cfg0_nxt = cfg0_r;
		cfg1_nxt = cfg1_r;
		cfg2_nxt = cfg2_r;
		ctrl_nxt = ctrl_r;
		dat_nxt = dat_r;
		ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
		if (wb_cyc_i && wb_stb_i && ack_r) begin
			if (wb_we_i && wb_sel_i[0]) begin
				case (wb_adr_i)
					`CTD_ADR_CFG0: cfg0_nxt = ctd_cfg0_t'(wb_dat_i[7:0]);
					`CTD_ADR_CFG1: cfg1_nxt = ctd_cfg1_t'(wb_dat_i[7:0]);
					`CTD_ADR_CFG2: cfg2_nxt = wb_dat_i[7:0];
					`CTD_ADR_CTRL: ctrl_nxt = ctd_ctrl_t'(wb_dat_i[1:0]);
					default: ;
				endcase
			end
		end
		if (ack_nxt) begin
			case (wb_adr_i)
				`CTD_ADR_CFG0: dat_nxt = {24'h00_0000, cfg0_r};
				`CTD_ADR_CFG1: dat_nxt = {24'h00_0000, cfg1_r};
				`CTD_ADR_CFG2: dat_nxt = {24'h00_0000, cfg2_r};
				`CTD_ADR_CTRL: dat_nxt = {30'h0000_0000, ctrl_r};
				`CTD_ADR_STAT: dat_nxt = {25'h000_0000, first_r, hold_r, filt_halt,
					prox_r, state_r == CTD_ST_TOUCH, state_r};
				`CTD_ADR_BASE: dat_nxt = {16'h0000, base_r};
				`CTD_ADR_CNT: dat_nxt = {16'h0000, count_r};
				default: dat_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			cfg0_r <= ctd_cfg0_t'(`CTD_CFG0_RST);
			cfg1_r <= ctd_cfg1_t'(`CTD_CFG1_RST);
			cfg2_r <= `CTD_CFG2_RST;
			ctrl_r <= ctd_ctrl_t'(`CTD_CTRL_RST);
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			cfg0_r <= cfg0_nxt;
			cfg1_r <= cfg1_nxt;
			cfg2_r <= cfg2_nxt;
			ctrl_r <= ctrl_nxt;
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	////////////////////////////////////////////////////////////////////////////////
	// Sample tick, transfer enable and control pin timing.
	always_comb begin
		tick = (tick_cnt_r == TICK_LAST);
		tick_cnt_nxt = tick ? 16'h0000 : tick_cnt_r + 16'h0001;
		xfer_en = (xfer_cnt_r >= (cfg2_r[6] ? XFER_SLOW : XFER_FAST));
		xfer_cnt_nxt = xfer_en ? 8'h00 : xfer_cnt_r + 8'h01;
		pin_d_nxt = pin_d_r;
		hi_nxt = hi_r;
		cmd_reseed = 1'b0;
		cmd_retune = 1'b0;
		if (tick && cfg0_r.in_en) begin
			pin_d_nxt = prox_out_cmd_pin_i;
			if (prox_out_cmd_pin_i) begin
				hi_nxt = (hi_r == 16'hffff) ? hi_r : hi_r + 16'h0001;
			end else begin
				hi_nxt = 16'h0000;
				if (pin_d_r && hi_r > 16'(`CTD_PULSE_MIN_MS) &&
					hi_r < 16'(`CTD_PULSE_MAX_MS)) begin
					cmd_retune = ctrl_r.pulse_retune;
					cmd_reseed = !ctrl_r.pulse_retune;
				end
			end
		end
		qual_hi = cfg0_r.in_en && pin_d_r && hi_r > 16'(`CTD_QUAL_MS);
		ext_charge_halt = qual_hi && !ctrl_r.filter_halt_mode;
		ext_filter_halt = qual_hi && ctrl_r.filter_halt_mode;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			tick_cnt_r <= 16'h0000;
			xfer_cnt_r <= 8'h00;
			pin_d_r <= 1'b0;
			hi_r <= 16'h0000;
		end else begin
			tick_cnt_r <= tick_cnt_nxt;
			xfer_cnt_r <= xfer_cnt_nxt;
			pin_d_r <= pin_d_nxt;
			hi_r <= hi_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Detection and baseline tracking; sample decisions happen on a conversion, halt timeout and pin commands do not wait for one.
	always_comb begin
		pthr = pthr_of(cfg0_r.pthr_code);
		tprod = base_r * tfrac_of(cfg0_r.tthr_code);
		tthr = tprod[23:8];
		rprod = tthr * (cfg0_r.rel_85 ? 2'd3 : 2'd3);
		relthr = cfg0_r.rel_85 ? 16'(({2'b00, tthr} * 18'd217) >> 8) : rprod[17:2];
		target = cfg2_r[3] ? `CTD_TARGET_LO : `CTD_TARGET_HI;
		halt_ticks = halt_of(cfg1_r.halt_code);
		dlt = $signed({1'b0, conv_count}) - $signed({1'b0, base_r});
		prox_hit = (dlt > $signed({1'b0, pthr})) || (-dlt > $signed({1'b0, pthr}));
		touch_hit = -dlt > $signed({1'b0, tthr});
		rel_hit = dlt >= $signed({1'b0, relthr});
		// A halt code of "never" freezes without limit, so no timeout is raised.
		halt_expired = (halt_ticks != 16'h0000) && (htmr_r >= halt_ticks) && !ext_filter_halt;
		filt_halt = ext_filter_halt || hold_r ||
			(state_r == CTD_ST_NOTOUCH && prox_r);
		touch_go = trun_r == (cfg1_r.fast_touch_entry ? 2'd1 : `CTD_TOUCH_RUN) - 2'd1;
		state_nxt = state_r;
		base_nxt = base_r;
		count_nxt = conv_valid ? conv_count : count_r;
		prox_nxt = prox_r;
		prun_nxt = prun_r;
		trun_nxt = trun_r;
		seed_nxt = seed_r;
		first_nxt = first_r;
		hold_nxt = hold_r;
		sby_req_nxt = sby_req_r || ext_charge_halt;
		tstart_nxt = 1'b0;
		htmr_nxt = (filt_halt && tick && htmr_r != 16'hffff) ? htmr_r + 16'h0001 : htmr_r;
		if (!filt_halt) begin
			htmr_nxt = 16'h0000;
		end
		case (state_r)
			CTD_ST_TUNE: begin
				if (tune_done) begin
					state_nxt = CTD_ST_NOTOUCH;
					seed_nxt = 1'b1;
					first_nxt = 1'b1;
				end
			end
			CTD_ST_STANDBY: begin
				if (!ext_charge_halt && !(pin_d_r && cfg0_r.in_en)) begin
					state_nxt = CTD_ST_NOTOUCH;
					seed_nxt = 1'b1;
					sby_req_nxt = 1'b0;
				end
			end
			default: begin
				if (halt_expired) begin
					state_nxt = CTD_ST_NOTOUCH;
					seed_nxt = 1'b1;
					prox_nxt = 1'b0;
					hold_nxt = 1'b0;
				end else if (conv_valid && sby_req_r) begin
					state_nxt = CTD_ST_STANDBY;
				end else if (conv_valid && seed_r) begin
					base_nxt = conv_count;
					seed_nxt = 1'b0;
					prun_nxt = 3'd0;
					trun_nxt = 2'd0;
					if (conv_count < (target >> 1) || conv_count > target + (target >> 1)) begin
						state_nxt = CTD_ST_TUNE;
						tstart_nxt = 1'b1;
					end
				end else if (conv_valid && state_r == CTD_ST_NOTOUCH) begin
					prun_nxt = prox_hit ? ((prun_r == `CTD_PROX_RUN) ? prun_r : prun_r + 3'd1) : 3'd0;
					prox_nxt = prox_hit && prun_r >= `CTD_PROX_RUN - 3'd1;
					trun_nxt = touch_hit ? trun_r + 2'd1 : 2'd0;
					if (touch_hit && touch_go) begin
						state_nxt = CTD_ST_TOUCH;
						base_nxt = base_r - tthr;
						trun_nxt = 2'd0;
						hold_nxt = cfg1_r.fast_touch_entry && !prox_r;
						prox_nxt = 1'b1;
					end else if (!filt_halt) begin
						base_nxt = 16'($signed({1'b0, base_r}) + (dlt >>> `CTD_FILT_SHIFT));
					end
				end else if (conv_valid && state_r == CTD_ST_TOUCH) begin
					if (rel_hit) begin
						state_nxt = CTD_ST_NOTOUCH;
						prox_nxt = 1'b0;
						prun_nxt = 3'd0;
						hold_nxt = 1'b0;
					end else if (!hold_r && !ext_filter_halt) begin
						base_nxt = 16'($signed({1'b0, base_r}) + (dlt >>> `CTD_FILT_SHIFT));
					end
				end
			end
		endcase
		if (cmd_reseed && state_r != CTD_ST_TUNE && state_r != CTD_ST_STANDBY) begin
			state_nxt = CTD_ST_NOTOUCH;
			seed_nxt = 1'b1;
			prox_nxt = 1'b0;
			hold_nxt = 1'b0;
		end
		if (cmd_retune) begin
			state_nxt = CTD_ST_TUNE;
			tstart_nxt = 1'b1;
			prox_nxt = 1'b0;
			hold_nxt = 1'b0;
			sby_req_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state_r <= CTD_ST_TUNE;
			base_r <= 16'h0000;
			count_r <= 16'h0000;
			prox_r <= 1'b0;
			prun_r <= 3'd0;
			trun_r <= 2'd0;
			seed_r <= 1'b0;
			first_r <= 1'b0;
			hold_r <= 1'b0;
			sby_req_r <= 1'b0;
			htmr_r <= 16'h0000;
			tstart_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			base_r <= base_nxt;
			count_r <= count_nxt;
			prox_r <= prox_nxt;
			prun_r <= prun_nxt;
			trun_r <= trun_nxt;
			seed_r <= seed_nxt;
			first_r <= first_nxt;
			hold_r <= hold_nxt;
			sby_req_r <= sby_req_nxt;
			htmr_r <= htmr_nxt;
			tstart_r <= tstart_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Open-drain only pulls when active, so the pin floats high on an idle bus.
	logic touch_act, prox_act;
	always_comb begin
		touch_act = state_r == CTD_ST_TOUCH || (state_r == CTD_ST_NOTOUCH && prox_r);
		prox_act = prox_r;
		charge_en = state_r != CTD_ST_STANDBY;
		tune_start = tstart_r;
		tune_target = target;
		ac_filter_en = !cfg1_r.fast_touch_entry;
		if (cfg0_r.pol_high) begin
			touch_output_pin_o = touch_act || !first_r;
			touch_output_pin_oe = 1'b1;
			prox_out_cmd_pin_o = prox_act || !first_r;
			prox_out_cmd_pin_oe = !cfg0_r.in_en;
		end else begin
			touch_output_pin_o = 1'b0;
			touch_output_pin_oe = touch_act;
			prox_out_cmd_pin_o = 1'b0;
			prox_out_cmd_pin_oe = prox_act && !cfg0_r.in_en;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	AST_PROX_SIX: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(prox_r) && $past(state_r) == CTD_ST_NOTOUCH && $past(state_r) == state_r
		|-> $past(prun_r) >= 3'd5)
		else $error("proximity raised before six samples");
	AST_TOUCH_RELOAD: assert property (@(posedge clk_sys) disable iff (!resetn)
		state_r == CTD_ST_NOTOUCH && state_nxt == CTD_ST_TOUCH |=> base_r == $past(base_r) - $past(tthr))
		else $error("touch entry did not reload baseline");
	AST_RELEASE: assert property (@(posedge clk_sys) disable iff (!resetn)
		state_r == CTD_ST_TOUCH && conv_valid && rel_hit && !seed_r && !sby_req_r && !halt_expired
		&& !cmd_retune |=> state_r == CTD_ST_NOTOUCH)
		else $error("release not taken");
	AST_STANDBY: assert property (@(posedge clk_sys) disable iff (!resetn)
		state_r inside {CTD_ST_NOTOUCH, CTD_ST_TOUCH} && conv_valid && sby_req_r && !halt_expired
		&& !cmd_retune |=> state_r == CTD_ST_STANDBY && !charge_en)
		else $error("charge running in standby");
	AST_WAKE_SEED: assert property (@(posedge clk_sys) disable iff (!resetn)
		$past(state_r) == CTD_ST_STANDBY && state_r == CTD_ST_NOTOUCH |-> seed_r)
		else $error("no reseed after standby");
	AST_CMD_SEED: assert property (@(posedge clk_sys) disable iff (!resetn)
		cmd_reseed && state_r inside {CTD_ST_NOTOUCH, CTD_ST_TOUCH} |=> seed_r && state_r != CTD_ST_TOUCH)
		else $error("reseed pulse not honoured");
	AST_RETUNE: assert property (@(posedge clk_sys) disable iff (!resetn)
		cmd_retune |=> state_r == CTD_ST_TUNE ##0 tune_start)
		else $error("retune pulse not honoured");
	AST_FROZEN: assert property (@(posedge clk_sys) disable iff (!resetn)
		state_r == CTD_ST_NOTOUCH && prox_r && !seed_r && state_nxt == CTD_ST_NOTOUCH
		|=> $stable(base_r))
		else $error("baseline moved during proximity");
	AST_POL_START: assert property (@(posedge clk_sys) disable iff (!resetn)
		cfg0_r.pol_high && !first_r |-> touch_output_pin_o && touch_output_pin_oe)
		else $error("active-high output low before first tune");
	AST_PTHR: assert property (@(posedge clk_sys) disable iff (!resetn)
		cfg0_r.pthr_code == 2'b01 |-> pthr == 16'h0002)
		else $error("proximity threshold decode wrong");
	CV_TOUCH: cover property (@(posedge clk_sys) disable iff (!resetn)
		state_r == CTD_ST_NOTOUCH ##1 state_r == CTD_ST_TOUCH);
	CV_STANDBY: cover property (@(posedge clk_sys) disable iff (!resetn)
		state_r == CTD_ST_STANDBY ##1 state_r == CTD_ST_NOTOUCH);
	CV_PULSE: cover property (@(posedge clk_sys) disable iff (!resetn) cmd_reseed);
	CV_TIMEOUT: cover property (@(posedge clk_sys) disable iff (!resetn) halt_expired);
endmodule

/* ctd_host_model.sv */
`timescale 1ns/1ps
module ctd_host_model #(
	parameter int TICK_CYCLES = 10
) (
	input wire logic clk_sys,
	input wire logic touch_o,
	input wire logic touch_oe,
	output logic ctrl_drive,
	output logic touch_level
);
	// The host drives the control line at all times, because a floating line reads as a halt.
	initial ctrl_drive = 1'b0;
	// Open-drain output with an external pull-up: a released pin reads high.
	assign touch_level = touch_oe ? touch_o : 1'b1;
	////////////////////////////////////////////////////////////////////////////////
	task automatic set_ctrl(input logic v);
		@(posedge clk_sys);
		ctrl_drive <= v;
	endtask
	task automatic pulse(input int ticks);
		set_ctrl(1'b1);
		repeat (ticks * TICK_CYCLES) @(posedge clk_sys);
		ctrl_drive <= 1'b0;
		repeat (3 * TICK_CYCLES) @(posedge clk_sys);
	endtask
endmodule

/* test_ctd_detect.sv */
`timescale 1ns/1ps
module test_ctd_detect import ctd_pkg::*; ;
	localparam int TK = 10;
	logic clk_sys, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, conv_valid, tune_done;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rdata;
	logic [15:0] conv_count, tune_target;
	logic charge_en, tune_start, xfer_en, ac_filter_en, t_o, t_oe, p_o, p_oe, ctrl, t_lvl;
	int mismatches = 0;
	int n_checks = 0;
	int nts = 0;
	int xcnt = 0;
	int xper = 0;
	ctd_detect #(.TICK_CYCLES(TK), .HALT_20S_TICKS(30), .HALT_40S_TICKS(60)) i_ctd_detect (
		.clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_valid(conv_valid),
		.conv_count(conv_count), .tune_done(tune_done), .charge_en(charge_en),
		.tune_start(tune_start), .tune_target(tune_target), .xfer_en(xfer_en),
		.ac_filter_en(ac_filter_en), .touch_output_pin_o(t_o), .touch_output_pin_oe(t_oe),
		.prox_out_cmd_pin_i(ctrl), .prox_out_cmd_pin_o(p_o), .prox_out_cmd_pin_oe(p_oe)
	);
	ctd_host_model #(.TICK_CYCLES(TK)) i_ctd_host_model (
		.clk_sys(clk_sys), .touch_o(t_o), .touch_oe(t_oe), .ctrl_drive(ctrl), .touch_level(t_lvl)
	);
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (tune_start === 1'b1 && resetn === 1'b1) nts <= nts + 1;
		if (xfer_en === 1'b1) begin
			xper <= xcnt;
			xcnt <= 1;
		end else xcnt <= xcnt + 1;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("mismatches %0d n_checks %0d", mismatches, n_checks);
		if (mismatches == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_sys);
		end while (wb_ack_o !== 1'b1);
		rdata = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk(nm, e, rdata & m);
	endtask
	task automatic st(input ctd_state_t e);
		rchk("state", 8'h10, 32'h0000_0003, {30'h0, e});
	endtask
	task automatic conv(input logic [15:0] c);
		@(posedge clk_sys);
		conv_valid <= 1'b1;
		conv_count <= c;
		@(posedge clk_sys);
		conv_valid <= 1'b0;
		conv_count <= ~c;
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic tdone;
		@(posedge clk_sys);
		tune_done <= 1'b1;
		@(posedge clk_sys);
		tune_done <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (30000) @(posedge clk_sys);
		mismatches++;
		close_out;
	end
	initial begin
		int n0;
		resetn = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h1;
		wb_dat_i = 32'h0000_0000;
		conv_valid = 1'b0;
		conv_count = 16'h0000;
		tune_done = 1'b0;
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk("tune start", 32'h0000_0001, 32'(nts));
		for (int a = 0; a < 16; a += 4) rchk("reset cfg", 8'(a), 32'h0000_00ff, 32'h0000_0000);
		st(CTD_ST_TUNE);
		rchk("unmapped", 8'h1c, 32'hffff_ffff, 32'h0000_0000);
		// A write without lane 0 enabled must leave the register alone.
		wb_sel_i <= 4'h0;
		wb(1'b1, 8'h04, 32'h0000_00ff);
		wb_sel_i <= 4'h1;
		rchk("lane off", 8'h04, 32'h0000_00ff, 32'h0000_0000);
		wb(1'b1, 8'h00, 32'h0000_0020);
		@(posedge clk_sys);
		chk("pin high", 32'h0000_0003, 32'({t_o, t_oe}));
		chk("prox pin", 32'h0000_0003, 32'({p_o, p_oe}));
		wb(1'b1, 8'h08, 32'h0000_0040);
		repeat (450) @(posedge clk_sys);
		chk("xfer period", 32'h0000_00c8, 32'(xper));
		chk("target", 32'h0000_04b0, 32'(tune_target));
		wb(1'b1, 8'h08, 32'h0000_0008);
		repeat (250) @(posedge clk_sys);
		chk("xfer period", 32'h0000_0061, 32'(xper));
		chk("target", 32'h0000_0400, 32'(tune_target));
		wb(1'b1, 8'h04, 32'h0000_0008);
		@(posedge clk_sys);
		chk("ac filter", 32'h0000_0000, 32'(ac_filter_en));
		wb(1'b1, 8'h04, 32'h0000_0000);
		@(posedge clk_sys);
		chk("ac filter", 32'h0000_0001, 32'(ac_filter_en));
		// Input mode, open drain, touch code 001 and proximity code 00 on a 1024 baseline.
		wb(1'b1, 8'h00, 32'h0000_0084);
		tdone;
		st(CTD_ST_NOTOUCH);
		i_ctd_host_model.pulse(30);
		chk("pin idle", 32'h0000_0000, 32'({t_o, t_oe}));
		conv(16'h0400);
		rchk("base", 8'h14, 32'h0000_ffff, 32'h0000_0400);
		// Before proximity the filter steps the baseline one count toward each sample.
		repeat (5) conv(16'h03f6);
		rchk("prox", 8'h10, 32'h0000_0008, 32'h0000_0000);
		rchk("base", 8'h14, 32'h0000_ffff, 32'h0000_03fb);
		conv(16'h03f6);
		rchk("prox", 8'h10, 32'h0000_0008, 32'h0000_0008);
		chk("pin prox", 32'h0000_0001, 32'({t_o, t_oe}));
		chk("touch level", 32'h0000_0000, 32'(t_lvl));
		rchk("base", 8'h14, 32'h0000_ffff, 32'h0000_03fa);
		conv(16'h03e8);
		rchk("base", 8'h14, 32'h0000_ffff, 32'h0000_03fa);
		st(CTD_ST_NOTOUCH);
		conv(16'h03e8);
		st(CTD_ST_TOUCH);
		rchk("base", 8'h14, 32'h0000_ffff, 32'h0000_03eb);
		conv(16'h03cb);
		rchk("base", 8'h14, 32'h0000_ffff, 32'h0000_03e9);
		conv(16'h03f3);
		st(CTD_ST_TOUCH);
		conv(16'h03f4);
		st(CTD_ST_NOTOUCH);
		// A proximity that outlasts the 30-tick halt must reseed onto the held count.
		repeat (45) begin
			conv(16'h03fa);
			repeat (6) @(posedge clk_sys);
		end
		rchk("base", 8'h14, 32'h0000_ffff, 32'h0000_03fa);
		rchk("prox", 8'h10, 32'h0000_0008, 32'h0000_0000);
		chk("pin idle", 32'h0000_0000, 32'({t_o, t_oe}));
		chk("touch level", 32'h0000_0001, 32'(t_lvl));
		i_ctd_host_model.pulse(20);
		conv(16'h0406);
		rchk("base", 8'h14, 32'h0000_ffff, 32'h0000_03fa);
		wb(1'b1, 8'h0c, 32'h0000_0002);
		n0 = nts;
		i_ctd_host_model.pulse(30);
		chk("retune", 32'(n0 + 1), 32'(nts));
		st(CTD_ST_TUNE);
		tdone;
		wb(1'b1, 8'h0c, 32'h0000_0000);
		n0 = nts;
		i_ctd_host_model.pulse(30);
		conv(16'h0190);
		chk("limit retune", 32'(n0 + 1), 32'(nts));
		st(CTD_ST_TUNE);
		tdone;
		i_ctd_host_model.set_ctrl(1'b1);
		repeat (45 * TK) @(posedge clk_sys);
		conv(16'h0400);
		st(CTD_ST_STANDBY);
		chk("charge", 32'h0000_0000, 32'(charge_en));
		i_ctd_host_model.set_ctrl(1'b0);
		repeat (3 * TK) @(posedge clk_sys);
		chk("charge", 32'h0000_0001, 32'(charge_en));
		conv(16'h0410);
		rchk("base", 8'h14, 32'h0000_ffff, 32'h0000_0410);
		wb(1'b1, 8'h0c, 32'h0000_0001);
		i_ctd_host_model.set_ctrl(1'b1);
		repeat (45 * TK) @(posedge clk_sys);
		conv(16'h0430);
		rchk("base", 8'h14, 32'h0000_ffff, 32'h0000_0410);
		i_ctd_host_model.set_ctrl(1'b0);
		repeat (3 * TK) @(posedge clk_sys);
		// Fast entry: one sample enters touch, and with no proximity the baseline is held.
		wb(1'b1, 8'h04, 32'h0000_0008);
		conv(16'h03f0);
		st(CTD_ST_TOUCH);
		rchk("base", 8'h14, 32'h0000_ffff, 32'h0000_0400);
		rchk("hold", 8'h10, 32'h0000_0020, 32'h0000_0020);
		conv(16'h03e0);
		rchk("base", 8'h14, 32'h0000_ffff, 32'h0000_0400);
		close_out;
	end
endmodule
